// ### include/phy_mgmt_pkg.sv
// shared constants and types for the phy management register block
package phy_mgmt_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam int unsigned DIAG_TIMEOUT_NS  = 50_000_000;
    localparam int unsigned DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_NS / CLK_PERIOD_NS;
    // register offsets
    localparam logic [4:0] REG_IRQ   = 5'h1b;
    localparam logic [4:0] REG_DIAG  = 5'h1d;
    localparam logic [4:0] REG_CTRL1 = 5'h1e;
    localparam logic [4:0] REG_CTRL2 = 5'h1f;
    // interrupt register layout
    localparam int unsigned NUM_EVT      = 8;
    localparam int unsigned IRQ_EN_LSB   = 8;
    localparam int unsigned IRQ_FLAG_LSB = 0;
    localparam int unsigned EVT_JABBER   = 7;
    localparam int unsigned EVT_RX_ERR   = 6;
    localparam int unsigned EVT_PAGE_RX  = 5;
    localparam int unsigned EVT_PD_FAULT = 4;
    localparam int unsigned EVT_LP_ACK   = 3;
    localparam int unsigned EVT_LINK_DN  = 2;
    localparam int unsigned EVT_REM_FLT  = 1;
    localparam int unsigned EVT_LINK_UP  = 0;
    localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
    localparam logic [7:0]  IRQ_FLAG_RST = 8'h00;
    // cable diagnostic register layout
    localparam int unsigned DIAG_START_BIT = 15;
    localparam int unsigned DIAG_RES_LSB   = 13;
    localparam int unsigned DIAG_SHORT_BIT = 12;
    localparam int unsigned DIAG_RSVD_LSB  = 9;
    localparam int unsigned DIAG_DIST_LSB  = 0;
    localparam logic [2:0]  DIAG_RSVD_RST  = 3'h0;
    localparam logic [8:0]  DIAG_DIST_RST  = 9'h000;
    // control 1 and control 2 layout
    localparam int unsigned CTRL1_PAUSE_BIT = 9;
    localparam int unsigned CTRL1_LINK_BIT  = 8;
    localparam int unsigned CTRL1_POL_BIT   = 7;
    localparam int unsigned CTRL2_LEVEL_BIT = 9;
    localparam logic        IRQ_LEVEL_RST   = 1'b0;
    // serial management frame
    localparam int unsigned PRE_BITS  = 32;
    localparam int unsigned HDR_BITS  = 14;
    localparam int unsigned DATA_BITS = 16;
    localparam logic [1:0]  ST_CODE   = 2'h1;
    localparam logic [1:0]  OP_RD     = 2'h2;
    localparam logic [1:0]  OP_WR     = 2'h1;
    // diagnostic outcome codes
    typedef enum logic [1:0] {
        DIAG_NORMAL = 2'h0,
        DIAG_OPEN   = 2'h1,
        DIAG_SHORT  = 2'h2,
        DIAG_FAIL   = 2'h3
    } diag_code_type;
    localparam diag_code_type DIAG_RES_RST = DIAG_NORMAL;
    // one-cycle event strobes from the phy core
    typedef struct packed {
        logic jabber;
        logic rx_err;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic remote_fault;
    } phy_events_type;
    // measurement returned by the cable test engine
    typedef struct packed {
        logic          done;
        diag_code_type code;
        logic          short_cable;
        logic [8:0]    distance;
    } diag_meas_type;
    // diagnostic status as seen by software
    typedef struct packed {
        logic          busy;
        diag_code_type code;
        logic          short_cable;
        logic [8:0]    distance;
    } diag_status_type;
endpackage

// ### hw/cable_diag_seq.sv
// cable diagnostic test sequencer with result holding and timeout
`timescale 1ns/1ps
`default_nettype none
module cable_diag_seq
#(
    parameter int unsigned TIMEOUT_CYC = phy_mgmt_pkg::DIAG_TIMEOUT_CYC
)
(
    input  wire logic                          mclk_in,
    input  wire logic                          nrst_in,
    input  wire logic                          start_in,
    input  wire phy_mgmt_pkg::diag_meas_type   meas_in,
    output var  logic                          run_out,
    output var  phy_mgmt_pkg::diag_status_type status_out
);
    import phy_mgmt_pkg::*;

    localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] LAST = TW'(TIMEOUT_CYC - 1);

    logic [TW-1:0] timer; // cycles spent in the current test

    // busy flag and result capture
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            status_out.busy        <= 1'b0;
            status_out.code        <= DIAG_RES_RST;
            status_out.short_cable <= 1'b0;
            status_out.distance    <= DIAG_DIST_RST;
        end
        else if (!status_out.busy)
        begin
            // a start while running is ignored
            if (start_in)
                status_out.busy <= 1'b1;
        end
        else if (meas_in.done)
        begin
            // results settle together with busy falling
            status_out.busy        <= 1'b0;
            status_out.code        <= meas_in.code;
            status_out.short_cable <= meas_in.short_cable;
            status_out.distance    <= meas_in.distance;
        end
        else if (timer == LAST)
        begin
            // engine never answered: report failure
            status_out.busy        <= 1'b0;
            status_out.code        <= DIAG_FAIL;
            status_out.short_cable <= 1'b0;
            status_out.distance    <= DIAG_DIST_RST;
        end
    end

    // timeout counter, cleared whenever idle
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            timer <= '0;
        else if (status_out.busy)
            timer <= timer + TW'(1);
        else
            timer <= '0;
    end

    // request level to the analog test engine
    assign run_out = status_out.busy;
endmodule
`default_nettype wire

// ### hw/phy_mgmt_regs.sv
// serial-managed interrupt, cable diagnostic and status registers
//
// Contract
// - bit 8 enables link-up interrupt, resets 0
// - bit 7 flags jabber, clears on read
// - bit 6 flags receive error, clears on read
// - bit 5 flags page received, clears on read
// - bit 4 flags parallel detect fault
// - bit 3 flags link partner acknowledge
// - bit 2 flags link going down
// - bit 1 flags remote fault
// - bit 0 flags link going up
// - writing start bit runs test, self-clears
// - results valid whenever start bit reads zero
// - result code: normal, open, short, failed
// - bit 12 marks cable under ten metres
// - bit 9 of control 1 shows pause capability
// - bit 7 of control 1 shows reversed polarity
// - event flags clear themselves when read
// - each flag has enable in upper byte
// - level bit selects interrupt pin polarity
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs
#(
    parameter logic [4:0]  PHY_ADDR    = 5'h00,
    parameter int unsigned TIMEOUT_CYC = phy_mgmt_pkg::DIAG_TIMEOUT_CYC
)
(
    input  wire logic                        mclk_in,
    input  wire logic                        nrst_in,
    input  wire logic                        mdc_in,
    input  wire logic                        mdio_in,
    output var  logic                        mdio_out,
    output var  logic                        mdio_oe_n_out,
    input  wire phy_mgmt_pkg::phy_events_type events_in,
    input  wire logic                        link_up_in,
    input  wire logic                        pause_capable_in,
    input  wire logic                        pol_reversed_in,
    input  wire phy_mgmt_pkg::diag_meas_type diag_meas_in,
    output var  logic                        diag_run_out,
    output var  logic                        irq_out
);
    import phy_mgmt_pkg::*;

    // frame states, gray along the path
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_HDR  = 3'h1,
        M_TA1  = 3'h3,
        M_TA2  = 3'h2,
        M_DATA = 3'h6
    } mdio_state_type;

    mdio_state_type  state;      // frame position
    logic            mdc_s1;     // clock pin sync stage 1
    logic            mdc_s2;     // clock pin sync stage 2
    logic            mdc_s3;     // delayed copy for edge find
    logic            mdio_s1;    // data pin sync stage 1
    logic            mdio_s2;    // data pin sync stage 2
    logic            rise;       // rising edge of management clock
    logic [5:0]      pre_cnt;    // consecutive preamble ones
    logic [4:0]      bit_cnt;    // header bits taken, data bits left
    logic [13:0]     hdr;        // start, opcode, addresses
    logic [13:0]     next_hdr;   // header with current bit
    logic            is_read;    // frame is a read
    logic [4:0]      reg_addr;   // addressed register
    logic [15:0]     rd_data;    // word being shifted out
    logic [15:0]     wr_data;    // word being shifted in
    logic [15:0]     next_wr;    // write word with current bit
    logic            hdr_done;   // last header bit sampled
    logic            hdr_ok;     // header addresses this device
    logic            rd_take;    // read word captured now
    logic            wr_commit;  // write word complete now
    logic [7:0]      irq_en;     // interrupt enables
    logic [7:0]      flags;      // sticky event flags
    logic [7:0]      evt;        // event strobes this cycle
    logic [7:0]      clr_mask;   // flags cleared by a read
    logic            link_q;     // link level last cycle
    logic            irq_level;  // interrupt pin polarity
    logic [2:0]      diag_rsvd;  // spare read-write bits
    logic            diag_start; // start request to sequencer
    diag_status_type diag_st;    // sequencer status

    // read value of one register
    function automatic logic [15:0] read_word(input logic [4:0] a);
        logic [15:0] w;
        w = 16'h0000;
        unique case (a)
            REG_IRQ:
            begin
                w[IRQ_EN_LSB +: NUM_EVT]   = irq_en;
                w[IRQ_FLAG_LSB +: NUM_EVT] = flags;
            end
            REG_DIAG:
            begin
                w[DIAG_START_BIT]      = diag_st.busy;
                w[DIAG_RES_LSB +: 2]   = diag_st.code;
                w[DIAG_SHORT_BIT]      = diag_st.short_cable;
                w[DIAG_RSVD_LSB +: 3]  = diag_rsvd;
                w[DIAG_DIST_LSB +: 9]  = diag_st.distance;
            end
            REG_CTRL1:
            begin
                w[CTRL1_PAUSE_BIT] = pause_capable_in;
                w[CTRL1_LINK_BIT]  = link_up_in;
                w[CTRL1_POL_BIT]   = pol_reversed_in;
            end
            REG_CTRL2:
                w[CTRL2_LEVEL_BIT] = irq_level;
            default:
                w = 16'h0000; // unmapped reads as zero
        endcase
        return w;
    endfunction

    // true when the register is the addressed one
    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction

    // two-stage synchronisers for both pins
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mdc_s1  <= 1'b0;
            mdc_s2  <= 1'b0;
            mdc_s3  <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end
        else
        begin
            mdc_s1  <= mdc_in;
            mdc_s2  <= mdc_s1;
            mdc_s3  <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    // frame decode terms
    assign rise      = mdc_s2 & ~mdc_s3;
    assign next_hdr  = {hdr[12:0], mdio_s2};
    assign next_wr   = {wr_data[14:0], mdio_s2};
    assign hdr_done  = (state == M_HDR) && rise && (bit_cnt == 5'(HDR_BITS - 1));
    assign hdr_ok    = (next_hdr[13:12] == ST_CODE)
                     && ((next_hdr[11:10] == OP_RD) || (next_hdr[11:10] == OP_WR))
                     && (next_hdr[9:5] == PHY_ADDR);
    assign rd_take   = hdr_done && hdr_ok && (next_hdr[11:10] == OP_RD);
    assign wr_commit = (state == M_DATA) && rise && !is_read && (bit_cnt == 5'h00);

    // preamble counter, saturating on ones
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            pre_cnt <= 6'h00;
        else if (state != M_IDLE)
            pre_cnt <= 6'h00; // restart after each frame
        else if (rise)
        begin
            if (!mdio_s2)
                pre_cnt <= 6'h00;
            else if (pre_cnt != 6'(PRE_BITS))
                pre_cnt <= pre_cnt + 6'h01;
        end
    end

    // frame state machine and bit counter
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state   <= M_IDLE;
            bit_cnt <= 5'h00;
            hdr     <= 14'h0000;
            is_read <= 1'b0;
        end
        else if (rise)
        begin
            unique case (state)
                M_IDLE:
                begin
                    // first zero after full preamble starts a frame
                    if (!mdio_s2 && pre_cnt == 6'(PRE_BITS))
                    begin
                        state   <= M_HDR;
                        bit_cnt <= 5'h01;
                        hdr     <= next_hdr;
                    end
                end
                M_HDR:
                begin
                    hdr <= next_hdr;
                    if (hdr_done)
                    begin
                        // foreign or malformed frames are dropped
                        state   <= hdr_ok ? M_TA1 : M_IDLE;
                        is_read <= next_hdr[11:10] == OP_RD;
                    end
                    else
                        bit_cnt <= bit_cnt + 5'h01;
                end
                M_TA1:
                    state <= M_TA2;
                M_TA2:
                begin
                    state   <= M_DATA;
                    bit_cnt <= 5'(DATA_BITS - 1);
                end
                M_DATA:
                begin
                    if (bit_cnt == 5'h00)
                        state <= M_IDLE;
                    else
                        bit_cnt <= bit_cnt - 5'h01;
                end
                default:
                    state <= M_IDLE;
            endcase
        end
    end

    // captured address and write shift register
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reg_addr <= 5'h00;
            wr_data  <= 16'h0000;
        end
        else
        begin
            if (hdr_done)
                reg_addr <= next_hdr[4:0];
            if (rise && state == M_DATA && !is_read)
                wr_data <= next_wr;
        end
    end

    // read word snapshot and pin drive
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_data       <= 16'h0000;
            mdio_out      <= 1'b1;
            mdio_oe_n_out <= 1'b1;
        end
        else if (rd_take)
            rd_data <= read_word(next_hdr[4:0]);
        else if (rise && is_read)
        begin
            unique case (state)
                M_TA1:
                begin
                    // second turnaround bit is driven low
                    mdio_out      <= 1'b0;
                    mdio_oe_n_out <= 1'b0;
                end
                M_TA2:
                    mdio_out <= rd_data[DATA_BITS-1];
                M_DATA:
                begin
                    if (bit_cnt == 5'h00)
                    begin
                        mdio_out      <= 1'b1;
                        mdio_oe_n_out <= 1'b1; // release after last bit
                    end
                    else
                        mdio_out <= rd_data[4'(bit_cnt[3:0] - 4'h1)];
                end
                default:
                begin
                    mdio_out      <= 1'b1;
                    mdio_oe_n_out <= 1'b1;
                end
            endcase
        end
    end

    // link transition detector
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            link_q <= 1'b0;
        else
            link_q <= link_up_in;
    end

    // event vector in flag bit order
    always_comb
    begin
        evt               = 8'h00;
        evt[EVT_JABBER]   = events_in.jabber;
        evt[EVT_RX_ERR]   = events_in.rx_err;
        evt[EVT_PAGE_RX]  = events_in.page_rx;
        evt[EVT_PD_FAULT] = events_in.pd_fault;
        evt[EVT_LP_ACK]   = events_in.lp_ack;
        evt[EVT_LINK_DN]  = link_q & ~link_up_in;
        evt[EVT_REM_FLT]  = events_in.remote_fault;
        evt[EVT_LINK_UP]  = ~link_q & link_up_in;
    end

    // reading the interrupt register clears all flags
    assign clr_mask = (rd_take && hit(next_hdr[4:0], REG_IRQ)) ? 8'hff : 8'h00;

    // sticky flags, a new event beats the clear
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            flags <= IRQ_FLAG_RST;
        else
            flags <= (flags & ~clr_mask) | evt;
    end

    // software-written control fields
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            irq_en    <= IRQ_EN_RST;
            irq_level <= IRQ_LEVEL_RST;
            diag_rsvd <= DIAG_RSVD_RST;
        end
        else if (wr_commit)
        begin
            if (hit(reg_addr, REG_IRQ))
                irq_en <= next_wr[IRQ_EN_LSB +: NUM_EVT];
            if (hit(reg_addr, REG_DIAG))
                diag_rsvd <= next_wr[DIAG_RSVD_LSB +: 3];
            if (hit(reg_addr, REG_CTRL2))
                irq_level <= next_wr[CTRL2_LEVEL_BIT];
        end
    end

    // a one in the start bit launches the test
    assign diag_start = wr_commit && hit(reg_addr, REG_DIAG)
                     && next_wr[DIAG_START_BIT];

    // test sequencer
    cable_diag_seq #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_diag (
        .mclk_in    (mclk_in),
        .nrst_in    (nrst_in),
        .start_in   (diag_start),
        .meas_in    (diag_meas_in),
        .run_out    (diag_run_out),
        .status_out (diag_st)
    );

    // interrupt pin with selectable polarity
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_out <= ~IRQ_LEVEL_RST;
        else if (|(flags & irq_en))
            irq_out <= irq_level;
        else
            irq_out <= ~irq_level;
    end
endmodule
`default_nettype wire

// ### bench/phy_mgmt_regs_checker.sv
// port-level assertions for the phy management register block
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs_checker
#(
    parameter int unsigned TIMEOUT_CYC = 64
)
(
    input wire logic                         mclk_in,
    input wire logic                         nrst_in,
    input wire logic                         mdc_in,
    input wire logic                         mdio_in,
    input wire logic                         mdio_out,
    input wire logic                         mdio_oe_n_out,
    input wire phy_mgmt_pkg::phy_events_type events_in,
    input wire logic                         link_up_in,
    input wire logic                         pause_capable_in,
    input wire logic                         pol_reversed_in,
    input wire phy_mgmt_pkg::diag_meas_type  diag_meas_in,
    input wire logic                         diag_run_out,
    input wire logic                         irq_out
);
    import phy_mgmt_pkg::*;
    logic        mdc_q;    // previous mdc level
    logic        link_q;   // previous link level
    logic [7:0]  rise_age; // cycles since last mdc rise, saturating
    logic [31:0] run_cnt;  // cycles the cable test has run
    wire         ev_any = (|events_in) || (link_up_in != link_q);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    // level history
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mdc_q  <= 1'b0;
            link_q <= 1'b0;
        end
        else
        begin
            mdc_q  <= mdc_in;
            link_q <= link_up_in;
        end
    end
    // age since the last management clock rise
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rise_age <= 8'hff;
        else if (mdc_in && !mdc_q)
            rise_age <= 8'h00;
        else if (rise_age != 8'hff)
            rise_age <= rise_age + 8'h01;
    end
    // length of the running cable test
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            run_cnt <= 32'h0;
        else
            run_cnt <= diag_run_out ? run_cnt + 32'h1 : 32'h0;
    end
    a_reset_idle: assert property ($rose(nrst_in) |-> irq_out
        && mdio_oe_n_out && !diag_run_out) else $error("outputs not idle after reset");
    a_irq_cause: assert property ($changed(irq_out) |-> rise_age < 16 || $past(ev_any)
        || $past(ev_any, 2) || $past(ev_any, 3)) else $error("irq moved without cause");
    a_run_cause: assert property ($rose(diag_run_out) |-> rise_age < 8'h10)
        else $error("test started without a write");
    a_run_done: assert property (diag_run_out && diag_meas_in.done
        |=> !diag_run_out) else $error("test busy after done");
    a_run_bounded: assert property (run_cnt <= TIMEOUT_CYC + 2)
        else $error("test ran past timeout");
    a_run_min: assert property (diag_run_out && !diag_meas_in.done && run_cnt < 32
        |=> diag_run_out) else $error("test ended early");
    a_drive_framed: assert property (!mdio_oe_n_out |-> rise_age < 8'h10)
        else $error("data driven outside a frame");
    a_bit_timing: assert property (!mdio_oe_n_out && $changed(mdio_out)
        |-> rise_age inside {[8'h01:8'h07]}) else $error("read bit changed off schedule");
endmodule
bind phy_mgmt_regs phy_mgmt_regs_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.*);
`default_nettype wire

// ### bench/mdio_host_model.sv
// station management host model driving serial frames into the device
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)
(
    input  wire logic mclk_in,
    input  wire logic mdio_in,
    output var  logic mdc_out,
    output var  logic mdio_out,
    output var  logic mdio_oe_n_out
);
    import phy_mgmt_pkg::*;
    // idle: clock still, line released to its pull-up
    initial
    begin
        mdc_out       = 1'b0;
        mdio_out      = 1'b1;
        mdio_oe_n_out = 1'b1;
    end
    // one frame; data moves on the low half, sampled on the rise
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] q);
        logic [63:0] fr;
        fr = {32'hffff_ffff, ST_CODE, op, PHY_ADDR, ra, 2'h2, wd};
        q = 16'h0000;
        @(posedge mclk_in);
        #7;
        for (int i = 63; i >= 0; i--)
        begin
            mdc_out       = 1'b0;
            mdio_oe_n_out = !((op == OP_WR) || (i > 17)); // reads release from turnaround
            mdio_out      = fr[i];
            #160;
            mdc_out = 1'b1;
            if (i < 16)
                q[i] = mdio_in; // read data, msb first
            #160;
        end
        mdc_out       = 1'b0;
        mdio_oe_n_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the phy management register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phy_mgmt_pkg::*;
    localparam int unsigned TMO = 1024;  // shortened timeout, outlasts one read frame
    logic           mclk_in;
    logic           nrst_in;
    logic           mdc, host_d, host_oe_n, mdio_out, mdio_oe_n_out;
    wire            mdio_wire = !mdio_oe_n_out ? mdio_out : (!host_oe_n ? host_d : 1'b1);
    phy_events_type events_in;
    logic           link_up_in, pause_capable_in, pol_reversed_in, diag_run_out, irq_out;
    diag_meas_type  diag_meas_in;
    int             err_count, total_checks;
    logic [15:0]    rd, prev;
    phy_mgmt_regs #(.PHY_ADDR(5'h00), .TIMEOUT_CYC(TMO)) DUT (.mclk_in(mclk_in),
        .nrst_in(nrst_in), .mdc_in(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
        .mdio_oe_n_out(mdio_oe_n_out), .events_in(events_in), .link_up_in(link_up_in),
        .pause_capable_in(pause_capable_in), .pol_reversed_in(pol_reversed_in),
        .diag_meas_in(diag_meas_in), .diag_run_out(diag_run_out), .irq_out(irq_out));
    mdio_host_model host (.mclk_in(mclk_in), .mdio_in(mdio_wire), .mdc_out(mdc),
        .mdio_out(host_d), .mdio_oe_n_out(host_oe_n));
    // 25 MHz clock
    initial mclk_in = 1'b0;
    always #20 mclk_in = ~mclk_in;
    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // register read with comparison
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp, input string what);
        host.xfer(OP_RD, ra, 16'h0000, rd);
        check(what, rd, exp);
    endtask
    // register write, then let it land
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        host.xfer(OP_WR, ra, wd, rd);
        repeat (4) @(posedge mclk_in);
        #1;
    endtask
    // raise the event source of flag bit b
    task automatic pulse(input int b);
        @(posedge mclk_in);
        if (b == 0 || b == 2)
            link_up_in <= (b == 0);
        else
            events_in <= phy_events_type'((b == 1) ? 6'h01 : 6'(1 << (b - 2)));
        @(posedge mclk_in);
        events_in <= '0;
        repeat (4) @(posedge mclk_in);
        #1;
    endtask
    // reset values, unmapped place, spare bits
    task automatic test_reset();
        check("irq idle", 16'(irq_out), 16'h0001);
        rd_chk(REG_IRQ, 16'h0000, "irq reset");
        rd_chk(REG_DIAG, 16'h0000, "diag reset");
        rd_chk(REG_CTRL1, 16'h0000, "ctrl1 reset");
        rd_chk(5'h10, 16'h0000, "unmapped");
        wr(REG_DIAG, 16'h7fff);
        rd_chk(REG_DIAG, 16'h0e00, "diag spare");
    endtask
    // every flag, jabber enable mask, clear on read, pin polarity
    task automatic test_events();
        wr(REG_IRQ, 16'hffff);
        rd_chk(REG_IRQ, 16'hff00, "enables");
        for (int b = 0; b < 8; b++)
        begin
            pulse(b);
            check("irq on", 16'(irq_out), 16'h0000);
            rd_chk(REG_IRQ, 16'hff00 | 16'h1 << b, "flag");
            rd_chk(REG_IRQ, 16'hff00, "flag cleared");
            check("irq off", 16'(irq_out), 16'h0001);
        end
        wr(REG_CTRL2, 16'h0200);
        check("irq high idle", 16'(irq_out), 16'h0000);
        pulse(7);
        check("irq high on", 16'(irq_out), 16'h0001);
        rd_chk(REG_IRQ, 16'hff80, "jabber");
        wr(REG_IRQ, 16'h7f00);
        pulse(7);
        check("masked irq", 16'(irq_out), 16'h0000);
        rd_chk(REG_IRQ, 16'h7f80, "masked flag");
    endtask
    // every result code, then a timeout
    task automatic test_diag();
        prev = 16'h0000;
        for (int c = 0; c < 4; c++)
        begin
            wr(REG_DIAG, 16'h8000);
            check("run", 16'(diag_run_out), 16'h0001);
            rd_chk(REG_DIAG, 16'h8000 | prev, "busy");
            @(posedge mclk_in);
            diag_meas_in <= '{1'b1, diag_code_type'(c[1:0]), c[0], 9'h0a5 + 9'(c)};
            @(posedge mclk_in);
            diag_meas_in.done <= 1'b0;
            prev = {1'b0, c[1:0], c[0], 3'h0, 9'h0a5 + 9'(c)};
            rd_chk(REG_DIAG, prev, "result");
            check("run done", 16'(diag_run_out), 16'h0000);
        end
        wr(REG_DIAG, 16'h8000);
        repeat (TMO + 4) @(posedge mclk_in);
        #1;
        check("run timeout", 16'(diag_run_out), 16'h0000);
        rd_chk(REG_DIAG, 16'h6000, "timeout");
    endtask
    // live status bits
    task automatic test_status();
        @(posedge mclk_in);
        pause_capable_in <= 1'b1;
        rd_chk(REG_CTRL1, 16'h0200, "pause");
        @(posedge mclk_in);
        pause_capable_in <= 1'b0;
        pol_reversed_in  <= 1'b1;
        rd_chk(REG_CTRL1, 16'h0080, "polarity");
    endtask
    // verdict and end of run
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #3_000_000;
        err_count++;
        finish_test();
    end
    // main sequence
    initial
    begin
        err_count        = 0;
        total_checks     = 0;
        nrst_in          = 1'b0;
        events_in        = '0;
        link_up_in       = 1'b0;
        pause_capable_in = 1'b0;
        pol_reversed_in  = 1'b0;
        diag_meas_in     = '0;
        repeat (4) @(posedge mclk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
        test_reset();
        test_events();
        test_diag();
        test_status();
        finish_test();
    end
endmodule
`default_nettype wire
